// ### verilog/acsti_core.sv
/*
 ASCII command interpreter with self-test, syntax errors and program
 sequencing. Takes received bus bytes one per cycle on rx_valid.
 Assumes the bus logic on the same clock delivers the bytes and pulses
 status_read / spoll_read when the status word / poll byte is read.
*/
// Behaviour
// R01: Self-test runs ROM check, LEDs, sets flag
// R02: Self-test keeps parameters and program memory
// R03: Command self-test never tests RAM
// R04: Flag set at reset, cleared on read
// R05: Any bad command discards whole string
// R06: Errors set matching serial poll bits
// R07: Service request only when previously enabled
// R08: Each error shows own message one second
// R09: Spaces skipped anywhere
// R10: Missing option means zero
// R11: Unknown letter gives illegal command error
// R12: Undefined option gives illegal option error
// R13: Not remote: error, execute nothing
// R14: Many commands form one transaction
// R15: Hundred steps of source, limit, dwell
// R16: Each step held for its dwell
// R17: Changes apply only on execute character
// R18: Message hold counter restarts per error
// R19: Only first error of string reported
`timescale 1ns/10ps
`include "acsti_map.svh"

module acsti_core
	import acsti_pkg::*;
#(
	parameter int MSG_HOLD_CYCLES = `ACSTI_MSG_HOLD_MS*`ACSTI_CLK_MHZ*1000,
	parameter int LED_CYCLES      = `ACSTI_LED_TEST_MS*`ACSTI_CLK_MHZ*1000,
	parameter int MS_CYCLES       = `ACSTI_DWELL_MS*`ACSTI_CLK_MHZ*1000
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        remote_pin,
	input  wire logic        status_read,
	input  wire logic        spoll_read,
	output acsti_live_t      live_state,
	output logic [15:0]      src_out,
	output logic [15:0]      lim_out,
	output logic [6:0]       step_out,
	output logic [2:0]       spoll_err,
	output logic             srq,
	output logic [1:0]       msg_code,
	output logic             led_all_on,
	output logic             self_test_flag,
	output logic             rom_fail
);

	// Decode of a command letter
	function automatic acsti_dec_t dec_letter(input logic [7:0] c);
		acsti_dec_t r;
		r = '{ok: 1'b1, kind: KIND_MODE, max: 16'h0000};
		unique case (c)
			`ACSTI_CH_D: r.max = `ACSTI_MAX_D;
			`ACSTI_CH_F: r.max = `ACSTI_MAX_F;
			`ACSTI_CH_G: r.max = `ACSTI_MAX_G;
			`ACSTI_CH_J: r.max = `ACSTI_MAX_J;
			`ACSTI_CH_M: r.max = `ACSTI_MAX_M;
			`ACSTI_CH_P: r.max = `ACSTI_MAX_P;
			`ACSTI_CH_T: r.max = `ACSTI_MAX_T;
			`ACSTI_CH_U: r.max = `ACSTI_MAX_U;
			`ACSTI_CH_I, `ACSTI_CH_V, `ACSTI_CH_W:
			begin
				r.kind = KIND_VALUE;
				r.max  = `ACSTI_MAX_VALUE;
			end
			`ACSTI_CH_L: r.kind = KIND_LOC;
			`ACSTI_CH_X: r.kind = KIND_EXEC;
			default:     r.ok   = 1'b0;
		endcase
		return r;
	endfunction : dec_letter

	// Constant table that the ROM test sums
	function automatic logic [7:0] rom_word(input logic [3:0] i);
		return {i, 4'h0} ^ {4'h0, i};
	endfunction : rom_word

	typedef enum logic [1:0] {T_IDLE, T_ROM, T_LED} acsti_tst_t;
	typedef enum logic [1:0] {S_FETCH, S_LOAD, S_HOLD} acsti_seq_t;

	logic         rem_s1_r, rem_r;     // Remote level synchroniser
	acsti_live_t  live_r, tmp_r;       // Live state, staging copy
	logic [7:0]   cur_r;               // Open letter, zero when none
	logic [15:0]  opt_r;               // Option being accumulated
	logic         ovf_r;               // Option overflowed
	acsti_err_t   err_r;               // First error of this string
	logic [2:0]   sp_r;                // Serial poll error bits
	logic         srq_r;
	logic [1:0]   msg_r;
	logic [31:0]  msg_cnt_r;           // Message hold down-counter
	acsti_tst_t   tst_r;
	logic [31:0]  tst_cnt_r;
	logic [7:0]   rom_sum_r;
	logic         led_r, flag_r, rom_fail_r;
	acsti_seq_t   seq_r;
	logic [6:0]   step_r;
	logic [15:0]  dwell_r;             // Milliseconds left in step
	logic [31:0]  ms_cnt_r;            // Cycles left in millisecond
	logic [15:0]  src_r, lim_r;
	acsti_step_t  rd_data;

	// Byte classification
	wire is_space = rx_byte == `ACSTI_CH_SPACE;
	wire is_digit = rx_byte >= `ACSTI_CH_ZERO && rx_byte <= `ACSTI_CH_NINE;
	wire is_alpha = rx_byte >= `ACSTI_CH_A && rx_byte <= `ACSTI_CH_Z;
	wire is_exec  = rx_byte == `ACSTI_CH_X;
	wire take     = rx_valid && !is_space;                        // R09

	// Option accumulation, ten times plus digit
	wire [19:0] opt_w = {opt_r, 3'b000} + {3'b000, opt_r, 1'b0}
	                    + {16'h0000, rx_byte[3:0]};

	// Check of the open letter when it closes
	wire acsti_dec_t cd    = dec_letter(cur_r);
	wire has_cur   = cur_r != 8'h00;
	wire loc_bad   = opt_r < `ACSTI_LOC_FIRST || opt_r > `ACSTI_LOC_LAST;
	wire close_now = take && is_alpha && has_cur;
	wire bad_cmd   = has_cur && !cd.ok;                          // R11
	wire bad_opt   = has_cur && cd.ok &&
	                 (ovf_r || (cd.kind == KIND_LOC ? loc_bad
	                           : opt_r > cd.max));               // R12
	wire stray     = take && !is_alpha && !(is_digit && has_cur);

	// Error of this byte: remote first, then command, then option
	wire acsti_err_t err_now =
		!rem_r                  ? ERR_REMOTE :                      // R13
		(close_now && bad_cmd)  ? ERR_CMD    :
		(close_now && bad_opt)  ? ERR_OPT    :
		stray                   ? ERR_CMD    : ERR_NONE;
	wire acsti_err_t err_nxt =
		(err_r != ERR_NONE || !take) ? err_r : err_now;             // R19
	wire end_str = take && is_exec;                                // R14
	wire exec_ok = end_str && err_nxt == ERR_NONE;                 // R05
	wire err_str = end_str && err_nxt != ERR_NONE;

	// Staging copy with the closing letter applied
	acsti_live_t tmp_apl;
	always_comb
	begin
		tmp_apl = tmp_r;
		if (close_now && !bad_cmd && !bad_opt)
		begin
			unique case (cur_r)                               // R10
				`ACSTI_CH_D: tmp_apl.d         = opt_r[0:0];
				`ACSTI_CH_F: tmp_apl.f         = opt_r[0:0];
				`ACSTI_CH_G: tmp_apl.g         = opt_r[2:0];
				`ACSTI_CH_J: tmp_apl.test_pend = 1'b1;
				`ACSTI_CH_M: tmp_apl.srq_en    = opt_r[0];
				`ACSTI_CH_P: tmp_apl.p         = opt_r[1:0];
				`ACSTI_CH_T: tmp_apl.t         = opt_r[2:0];
				`ACSTI_CH_U: tmp_apl.u         = opt_r[0:0];
				`ACSTI_CH_I:
				begin
					tmp_apl.step.source = opt_r;
					tmp_apl.wr_pend     = 1'b1;
				end
				`ACSTI_CH_V:
				begin
					tmp_apl.step.limit = opt_r;
					tmp_apl.wr_pend    = 1'b1;
				end
				`ACSTI_CH_W:
				begin
					tmp_apl.step.dwell = opt_r;
					tmp_apl.wr_pend    = 1'b1;
				end
				`ACSTI_CH_L: tmp_apl.loc = 7'(opt_r - 16'h0001);
				default:     tmp_apl = tmp_r;
			endcase
		end
	end

	// Live state after execute; one-shot marks never persist
	acsti_live_t live_new;
	always_comb
	begin
		live_new           = tmp_apl;
		live_new.wr_pend   = 1'b0;
		live_new.test_pend = 1'b0;
	end

	wire mem_wr = exec_ok && tmp_apl.wr_pend;
	wire run    = live_r.f == 1'b1 && live_r.p != 2'h0;
	wire [1:0] msg_new = err_nxt == ERR_CMD ? `ACSTI_MSG_CMD :
	                     err_nxt == ERR_OPT ? `ACSTI_MSG_OPT :
	                     `ACSTI_MSG_REMOTE;

	// Remote level from the bus pin, two stages
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rem_s1_r <= 1'b0;
			rem_r    <= 1'b0;
		end
		else
		begin
			rem_s1_r <= remote_pin;
			rem_r    <= rem_s1_r;
		end
	end

	// Parser; live state moves only on a clean execute
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			live_r <= '0;
			tmp_r  <= '0;
			cur_r  <= 8'h00;
			opt_r  <= 16'h0000;
			ovf_r  <= 1'b0;
			err_r  <= ERR_NONE;
		end
		else if (end_str)
		begin
			// String done; staging restarts from live
			if (exec_ok)
				live_r <= live_new;                           // R17
			tmp_r <= exec_ok ? live_new : live_r;                 // R05
			cur_r <= 8'h00;
			opt_r <= 16'h0000;
			ovf_r <= 1'b0;
			err_r <= ERR_NONE;
		end
		else if (take)
		begin
			tmp_r <= tmp_apl;
			err_r <= err_nxt;
			if (is_alpha)
			begin
				cur_r <= rx_byte;
				opt_r <= 16'h0000;
				ovf_r <= 1'b0;
			end
			else if (is_digit && has_cur)
			begin
				opt_r <= opt_w[15:0];
				ovf_r <= ovf_r || opt_w[19:16] != 4'h0;
			end
		end
	end

	// Poll bits, service request and message; set beats read clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sp_r      <= 3'h0;
			srq_r     <= 1'b0;
			msg_r     <= `ACSTI_MSG_NONE;
			msg_cnt_r <= 32'h0000_0000;
		end
		else if (err_str)
		begin
			sp_r[`ACSTI_SP_CMD]    <= err_nxt == ERR_CMD ||
			                          (sp_r[`ACSTI_SP_CMD] && !spoll_read);
			sp_r[`ACSTI_SP_OPT]    <= err_nxt == ERR_OPT ||
			                          (sp_r[`ACSTI_SP_OPT] && !spoll_read);
			sp_r[`ACSTI_SP_REMOTE] <= err_nxt == ERR_REMOTE ||
			                          (sp_r[`ACSTI_SP_REMOTE] && !spoll_read); // R06
			srq_r     <= live_r.srq_en || (srq_r && !spoll_read); // R07
			msg_r     <= msg_new;                                   // R08
			msg_cnt_r <= 32'(MSG_HOLD_CYCLES);                      // R18
		end
		else
		begin
			if (spoll_read)
			begin
				sp_r  <= 3'h0;
				srq_r <= 1'b0;
			end
			if (msg_cnt_r == 32'h0000_0001)
				msg_r <= `ACSTI_MSG_NONE;
			if (msg_cnt_r != 32'h0000_0000)
				msg_cnt_r <= msg_cnt_r - 32'h0000_0001;
		end
	end

	// Self-test: ROM sum, then all LEDs, then flag; no RAM pass
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tst_r      <= T_IDLE;
			tst_cnt_r  <= 32'h0000_0000;
			rom_sum_r  <= 8'h00;
			led_r      <= 1'b0;
			flag_r     <= 1'b1;                                     // R04
			rom_fail_r <= 1'b0;
		end
		else
		begin
			if (status_read)
				flag_r <= 1'b0;                                    // R04
			unique case (tst_r)
				T_IDLE:
					if (exec_ok && tmp_apl.test_pend)
					begin
						tst_r     <= T_ROM;                          // R01
						tst_cnt_r <= 32'h0000_0000;
						rom_sum_r <= 8'h00;
					end
				T_ROM:
					if (tst_cnt_r == 32'(`ACSTI_ROM_WORDS))
					begin
						rom_fail_r <= rom_sum_r != `ACSTI_ROM_SUM;
						led_r      <= 1'b1;
						tst_cnt_r  <= 32'(LED_CYCLES);
						tst_r      <= T_LED;                        // R03
					end
					else
					begin
						rom_sum_r <= rom_sum_r + rom_word(tst_cnt_r[3:0]);
						tst_cnt_r <= tst_cnt_r + 32'h0000_0001;
					end
				T_LED:
					if (tst_cnt_r <= 32'h0000_0001)
					begin
						led_r  <= 1'b0;
						flag_r <= 1'b1;                              // R01
						tst_r  <= T_IDLE;
					end
					else
						tst_cnt_r <= tst_cnt_r - 32'h0000_0001;
			endcase
		end
	end

	// Sequencer: fetch a step, hold it for its dwell, advance
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			seq_r    <= S_FETCH;
			step_r   <= 7'h00;
			dwell_r  <= 16'h0000;
			ms_cnt_r <= 32'h0000_0000;
			src_r    <= 16'h0000;
			lim_r    <= 16'h0000;
		end
		else if (!run)
			seq_r <= S_FETCH;
		else
		begin
			unique case (seq_r)
				S_FETCH: seq_r <= S_LOAD;
				S_LOAD:
				begin
					src_r    <= rd_data.source;
					lim_r    <= rd_data.limit;
					dwell_r  <= rd_data.dwell == 16'h0000 ? 16'h0001
					            : rd_data.dwell;
					ms_cnt_r <= 32'(MS_CYCLES);
					seq_r    <= S_HOLD;
				end
				S_HOLD:
					if (ms_cnt_r > 32'h0000_0001)
						ms_cnt_r <= ms_cnt_r - 32'h0000_0001;
					else if (dwell_r > 16'h0001)
					begin
						dwell_r  <= dwell_r - 16'h0001;
						ms_cnt_r <= 32'(MS_CYCLES);
					end
					else
					begin
						step_r <= step_r == `ACSTI_LAST_ADDR ? 7'h00
						          : step_r + 7'h01;                // R16
						seq_r  <= S_FETCH;
					end
			endcase
		end
	end

	// Step storage; written only by a clean execute
	acsti_prog_mem u_mem (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (mem_wr),                                          // R02
		.wr_addr (tmp_apl.loc),
		.wr_data (tmp_apl.step),
		.rd_addr (step_r),
		.rd_data (rd_data)
	);

	assign live_state     = live_r;
	assign src_out        = src_r;
	assign lim_out        = lim_r;
	assign step_out       = step_r;
	assign spoll_err      = sp_r;
	assign srq            = srq_r;
	assign msg_code       = msg_r;
	assign led_all_on     = led_r;
	assign self_test_flag = flag_r;
	assign rom_fail       = rom_fail_r;

endmodule : acsti_core

// ### verilog/acsti_map.svh
/*
 Constants for the ASCII command interpreter: characters, option limits,
 error and message codes, timing in its own unit.
 Assumes a 250 MHz system clock; counts are derived where they are used.
*/
`ifndef ACSTI_MAP_SVH
`define ACSTI_MAP_SVH

// Characters of the command language
`define ACSTI_CH_SPACE    8'h20
`define ACSTI_CH_ZERO     8'h30
`define ACSTI_CH_NINE     8'h39
`define ACSTI_CH_D        8'h44
`define ACSTI_CH_F        8'h46
`define ACSTI_CH_G        8'h47
`define ACSTI_CH_I        8'h49
`define ACSTI_CH_J        8'h4a
`define ACSTI_CH_L        8'h4c
`define ACSTI_CH_M        8'h4d
`define ACSTI_CH_P        8'h50
`define ACSTI_CH_T        8'h54
`define ACSTI_CH_U        8'h55
`define ACSTI_CH_V        8'h56
`define ACSTI_CH_W        8'h57
`define ACSTI_CH_X        8'h58
`define ACSTI_CH_A        8'h41
`define ACSTI_CH_Z        8'h5a

// Highest legal option of each mode letter
`define ACSTI_MAX_D       16'h0001
`define ACSTI_MAX_F       16'h0001
`define ACSTI_MAX_G       16'h0005
`define ACSTI_MAX_J       16'h0000
`define ACSTI_MAX_M       16'h0001
`define ACSTI_MAX_P       16'h0002
`define ACSTI_MAX_T       16'h0005
`define ACSTI_MAX_U       16'h0001
`define ACSTI_MAX_VALUE   16'hffff
`define ACSTI_LOC_FIRST   16'h0001
`define ACSTI_LOC_LAST    16'h0064

// Program memory
`define ACSTI_STEPS       100
`define ACSTI_ADDR_W      7
`define ACSTI_LAST_ADDR   7'h63

// Front panel message codes
`define ACSTI_MSG_NONE    2'h0
`define ACSTI_MSG_CMD     2'h1
`define ACSTI_MSG_OPT     2'h2
`define ACSTI_MSG_REMOTE  2'h3

// Serial poll error bit positions
`define ACSTI_SP_CMD      0
`define ACSTI_SP_OPT      1
`define ACSTI_SP_REMOTE   2

// Timing: clock rate and times in milliseconds
`define ACSTI_CLK_MHZ     250
`define ACSTI_MSG_HOLD_MS 1000
`define ACSTI_LED_TEST_MS 500
`define ACSTI_DWELL_MS    1

// Constant table checked by the ROM test
`define ACSTI_ROM_WORDS   16
`define ACSTI_ROM_SUM     8'hf8

`endif

// ### verilog/acsti_pkg.sv
/*
 Types of the ASCII command interpreter: operating state, program step,
 letter decode result, error kind.
 Assumes acsti_map.svh supplies the widths it needs.
*/
`include "acsti_map.svh"

package acsti_pkg;

	// Kind of option a letter carries
	typedef enum logic [1:0] {
		KIND_MODE,
		KIND_VALUE,
		KIND_LOC,
		KIND_EXEC
	} acsti_kind_t;

	// First error of a string
	typedef enum logic [1:0] {
		ERR_NONE,
		ERR_CMD,
		ERR_OPT,
		ERR_REMOTE
	} acsti_err_t;

	// Letter decode result
	typedef struct packed {
		logic        ok;
		acsti_kind_t kind;
		logic [15:0] max;
	} acsti_dec_t;

	// One program step: source, limit, dwell in milliseconds
	typedef struct packed {
		logic [15:0] source;
		logic [15:0] limit;
		logic [15:0] dwell;
	} acsti_step_t;

	// Live operating state, also the shape of the staging copy
	typedef struct packed {
		logic [0:0]              d;
		logic [0:0]              f;
		logic [2:0]              g;
		logic [1:0]              p;
		logic [2:0]              t;
		logic [0:0]              u;
		logic                    srq_en;
		logic [`ACSTI_ADDR_W-1:0] loc;
		acsti_step_t             step;
		logic                    wr_pend;
		logic                    test_pend;
	} acsti_live_t;

endpackage : acsti_pkg

// ### verilog/acsti_prog_mem.sv
/*
 Program memory of the interpreter: one write port, one read port,
 read data from a register.
 Assumes writes come from the execute step and reads from the sequencer.
*/
`timescale 1ns/10ps
`include "acsti_map.svh"

module acsti_prog_mem
	import acsti_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     wr_en,
	input  wire logic [`ACSTI_ADDR_W-1:0] wr_addr,
	input  wire acsti_step_t              wr_data,
	input  wire logic [`ACSTI_ADDR_W-1:0] rd_addr,
	output acsti_step_t                   rd_data
);

	acsti_step_t mem [0:`ACSTI_STEPS-1]; // Step storage, no reset
	acsti_step_t rd_r;                   // Registered read word

	// Array write; contents survive everything but a rewrite
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data; // R15
	end

	// Registered read
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rd_r <= '0;
		else
			rd_r <= mem[rd_addr];
	end

	assign rd_data = rd_r;

endmodule : acsti_prog_mem

// ### testbench/acsti_core_sva.sv
/*
 Port-level checker of the command interpreter.
 Assumes the bind in the bench top and the bench's shortened counts.
*/
`timescale 1ns/10ps
`include "acsti_map.svh"

module acsti_core_sva
	import acsti_pkg::*;
#(
	parameter int MSG_HOLD_CYCLES = 20,
	parameter int LED_CYCLES      = 5
)
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_byte,
	input wire logic        remote_pin,
	input wire logic        status_read,
	input wire logic        spoll_read,
	input wire acsti_live_t live_state,
	input wire logic [15:0] src_out,
	input wire logic [15:0] lim_out,
	input wire logic [6:0]  step_out,
	input wire logic [2:0]  spoll_err,
	input wire logic        srq,
	input wire logic [1:0]  msg_code,
	input wire logic        led_all_on,
	input wire logic        self_test_flag,
	input wire logic        rom_fail
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [2:0] prev_err_r; // Poll bits one cycle back
	logic [2:0] new_err;    // Bits raised this cycle
	logic [7:0] since_r;    // Cycles since the newest error
	logic [7:0] since;      // Same, zero on an error cycle
	logic [7:0] led_run_r;  // Cycles the LED test has lasted
	logic       seen_r;     // An error has been seen
	assign new_err = spoll_err & ~prev_err_r;
	assign since = (new_err != 3'h0) ? 8'h00 : since_r;

	// History; saturates so a long idle never wraps
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_err_r <= 3'h0;
			since_r    <= 8'hff;
			led_run_r  <= 8'h00;
			seen_r     <= 1'b0;
		end
		else
		begin
			prev_err_r <= spoll_err;
			since_r    <= (since == 8'hff) ? since : since + 8'h01;
			led_run_r  <= led_all_on ? led_run_r + 8'h01 : 8'h00;
			seen_r     <= seen_r | (new_err != 3'h0);
		end
	end

	a_srq_needs_en: assert property (
		$rose(srq) |-> $past(live_state.srq_en))
		else $error("service request without enable");
	a_err_at_exec: assert property (
		new_err != 3'h0 |-> $past(rx_valid) && $past(rx_byte) == `ACSTI_CH_X)
		else $error("error bit raised away from execute");
	a_msg_newest: assert property (
		new_err != 3'h0 |-> msg_code == (new_err[0] ? `ACSTI_MSG_CMD :
			new_err[1] ? `ACSTI_MSG_OPT : `ACSTI_MSG_REMOTE))
		else $error("message does not match newest error");
	a_msg_hold: assert property (
		seen_r |-> ((msg_code != 2'h0) == (since < MSG_HOLD_CYCLES)))
		else $error("message hold length wrong");
	a_live_on_exec: assert property (
		!$stable(live_state) |-> $past(rx_valid) &&
			$past(rx_byte) == `ACSTI_CH_X)
		else $error("live state changed without execute");
	a_no_remote: assert property (
		rx_valid && rx_byte == `ACSTI_CH_X && !remote_pin &&
		!$past(remote_pin, 1) && !$past(remote_pin, 2) &&
		!$past(remote_pin, 3) |=> $stable(live_state))
		else $error("command executed while not remote");
	a_flag_read: assert property (
		status_read && !led_all_on |=> !self_test_flag)
		else $error("self-test flag not cleared by read");
	a_flag_by_test: assert property (
		$fell(led_all_on) |-> self_test_flag)
		else $error("self-test flag not set at end of test");
	a_led_length: assert property (
		$fell(led_all_on) |-> led_run_r == LED_CYCLES)
		else $error("LED test length wrong");
	a_test_keeps: assert property (
		led_all_on |=> $stable(live_state))
		else $error("self-test changed live state");
	a_step_range: assert property (
		step_out <= `ACSTI_LAST_ADDR)
		else $error("step index out of range");
endmodule : acsti_core_sva

// ### testbench/acsti_ctrl_model.sv
/*
 Bus controller model: sends ASCII command strings byte by byte.
 Assumes the bench calls send and the interpreter shares its clock.
*/
`timescale 1ns/10ps

module acsti_ctrl_model
(
	input wire logic clk,
	output logic     rx_valid,
	output logic [7:0] rx_byte
);
	initial
	begin
		rx_valid = 1'b0;
		rx_byte  = 8'h00;
	end

	// Whole string as one transaction; gap gives a slow controller
	task automatic send(input string s, input int gap);
		for (int i = 0; i < s.len(); i++)
		begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_byte  = s[i];
			repeat (gap)
			begin
				@(negedge clk);
				rx_valid = 1'b0;
				rx_byte  = ~rx_byte; // No stale byte while idle
			end
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_byte  = ~rx_byte;
	endtask : send
endmodule : acsti_ctrl_model

// ### testbench/test_ascii_command_self_test_error.sv
/*
 Self-checking bench of the command interpreter.
 Assumes shortened counts; the controller model drives the byte stream.
*/
`timescale 1ns/10ps

module test_ascii_command_self_test_error
	import acsti_pkg::*;
;
	localparam int HOLD = 20; // Message hold, cycles
	localparam int LED  = 5;  // LED test, cycles
	localparam int MSC  = 3;  // One dwell unit, cycles
	logic        clk, resetn, remote_pin, status_read, spoll_read;
	logic        rx_valid, srq, led_all_on, self_test_flag, rom_fail;
	logic [7:0]  rx_byte;
	logic [15:0] src_out, lim_out, a, c;
	logic [6:0]  step_out;
	logic [2:0]  spoll_err, prev_poll;
	logic [1:0]  msg_code;
	logic [31:0] seed;
	logic [5:0]  exp_q[$]; // Notes: srq, poll bits, message
	acsti_live_t live_state, keep;
	int          fails, n_tests, cnt;
	string       bad[10] = '{"T9X", "F1H0T9X", "J1X", "L101X", "L0X",
		"I65536X", "5X", "P3X", "G6X", "U2X"};
	logic [1:0]  bad_m[10] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h2,
		2'h2, 2'h1, 2'h2, 2'h2, 2'h2};

	acsti_core #(.MSG_HOLD_CYCLES(HOLD), .LED_CYCLES(LED),
		.MS_CYCLES(MSC)) uut (
		.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .remote_pin(remote_pin),
		.status_read(status_read), .spoll_read(spoll_read),
		.live_state(live_state), .src_out(src_out), .lim_out(lim_out),
		.step_out(step_out), .spoll_err(spoll_err), .srq(srq),
		.msg_code(msg_code), .led_all_on(led_all_on),
		.self_test_flag(self_test_flag), .rom_fail(rom_fail));
	acsti_ctrl_model ctrl (.clk(clk), .rx_valid(rx_valid),
		.rx_byte(rx_byte));

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : check

	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// Bounded wait on the LED test; a hang ends the run
	task automatic wait_led(input logic v);
		for (int k = 0; k < 200 && led_all_on !== v; k++)
			@(negedge clk);
		if (led_all_on !== v)
		begin
			check("led wait", {15'h0, v}, {15'h0, led_all_on});
			final_report;
		end
	endtask : wait_led

	// Poll read; clears the sticky error bits and request
	task automatic poll_clear;
		@(negedge clk);
		spoll_read = 1'b1;
		@(negedge clk);
		spoll_read = 1'b0;
		check("poll", 16'h0, {12'h0, srq, spoll_err});
	endtask : poll_clear

	// Bad string: note the result, string must leave no trace
	task automatic err(input string s, input logic [1:0] m, input logic q);
		keep = live_state;
		exp_q.push_back({q, 3'h1 << (m - 2'h1), m});
		ctrl.send(s, 0);
		idle(2);
		check("kept", 16'h1, {15'h0, live_state === keep});
		poll_clear;
	endtask : err

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Takes the oldest note whenever a new error bit shows
	always @(negedge clk)
	begin
		if (resetn === 1'b1 && (spoll_err & ~prev_poll) !== 3'h0)
		begin
			if (exp_q.size() == 0)
				check("note", 16'h0, 16'h1);
			else
				check("error", {10'h0, exp_q.pop_front()},
					{10'h0, srq, spoll_err, msg_code});
		end
		prev_poll = spoll_err;
	end

	initial
	begin
		resetn = 1'b0;
		remote_pin = 1'b1;
		status_read = 1'b0;
		spoll_read = 1'b0;
		prev_poll = 3'h0;
		seed = 32'hf973;
		idle(16);
		resetn = 1'b1;
		check("flag", 16'h1, {15'h0, self_test_flag});
		status_read = 1'b1;
		idle(1);
		status_read = 1'b0;
		idle(1);
		check("flag", 16'h0, {15'h0, self_test_flag});
		// Spaces and several commands in one string
		ctrl.send("F1 D1 U1X", 0);
		idle(2);
		check("dfu", 16'h7, {13'h0, live_state.d, live_state.f,
			live_state.u});
		ctrl.send("D0 U", 2);
		idle(3);
		check("dfu", 16'h7, {13'h0, live_state.d, live_state.f,
			live_state.u});
		ctrl.send("X", 0);
		idle(2);
		check("dfu", 16'h2, {13'h0, live_state.d, live_state.f,
			live_state.u});
		err("H1X", 2'h1, 1'b0);
		ctrl.send("M1X", 0);
		for (int i = 0; i < 10; i++)
			err(bad[i], bad_m[i], 1'b1);
		// Second error restarts the message with its own code
		exp_q.push_back({4'h9, 2'h1});
		exp_q.push_back({4'hb, 2'h2});
		ctrl.send("H1X", 0);
		idle(5);
		ctrl.send("T9X", 0);
		idle(HOLD + 3);
		check("msg", 16'h0, {14'h0, msg_code});
		poll_clear;
		// Program steps; random values, last slot at the boundary
		seed = lfsr(seed);
		a = seed[15:0] | 16'h0001;
		c = ~a;
		ctrl.send($sformatf("L1I%0dV%0dW1X", a, seed[31:16]), 0);
		ctrl.send($sformatf("L2 I%0d V7 W2X", c), 0);
		ctrl.send("L100I5X", 0);
		idle(2);
		// Self-test keeps state and memory
		keep = live_state;
		ctrl.send("J0X", 0);
		wait_led(1'b1);
		wait_led(1'b0);
		idle(1);
		check("flag", 16'h1, {15'h0, self_test_flag});
		check("rom", 16'h0, {15'h0, rom_fail});
		check("kept", 16'h1, {15'h0, live_state === keep});
		// Run and time the second step
		ctrl.send("F1P1X", 0);
		for (int k = 0; k < 60 && src_out !== a; k++)
			@(negedge clk);
		check("src", a, src_out);
		check("lim", seed[31:16], lim_out);
		for (int k = 0; k < 60 && src_out === a; k++)
			@(negedge clk);
		check("step", 16'h1, {9'h0, step_out});
		for (cnt = 0; cnt < 60 && src_out === c; cnt++)
			@(negedge clk);
		check("dwell", 16'h1, {15'h0, cnt >= 2 * MSC &&
			cnt <= 2 * MSC + 2});
		ctrl.send("F0X", 0);
		// Not remote: error, nothing executed
		remote_pin = 1'b0;
		idle(5);
		err("G1X", 2'h3, 1'b1);
		remote_pin = 1'b1;
		idle(3);
		check("notes", 16'h0, 16'(exp_q.size()));
		final_report;
	end
endmodule : test_ascii_command_self_test_error

bind acsti_core acsti_core_sva #(.MSG_HOLD_CYCLES(MSG_HOLD_CYCLES),
	.LED_CYCLES(LED_CYCLES)) chk (
	.clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_byte(rx_byte),
	.remote_pin(remote_pin), .status_read(status_read),
	.spoll_read(spoll_read), .live_state(live_state), .src_out(src_out),
	.lim_out(lim_out), .step_out(step_out), .spoll_err(spoll_err),
	.srq(srq), .msg_code(msg_code), .led_all_on(led_all_on),
	.self_test_flag(self_test_flag), .rom_fail(rom_fail));
